// >>> core/fifo_flag_core.sv
// Status flags, offset load/readback and output word of a bus-matched FIFO
`timescale 1ns/1ps
module fifo_flag_core #(
  parameter int          DEPTH       = fifo_flag_pkg::DEPTH_WORDS,
  parameter logic [15:0] EMPTY_OFS_0 = fifo_flag_pkg::EMPTY_OFS_RESET,
  parameter logic [15:0] FULL_OFS_0  = fifo_flag_pkg::FULL_OFS_RESET
) (
  // Clock and reset
  input  wire logic                              core_clk_in,
  input  wire logic                              rst_n_in,
  // Device resets and straps
  input  wire logic                              master_reset_n_in,
  input  wire logic                              partial_reset_n_in,
  input  wire logic                              fall_through_mode_in,
  input  wire logic                              prog_flag_timing_select_in,
  input  wire logic                              parity_placement_select_in,
  input  wire logic                              in_wide_in,
  input  wire logic                              out_wide_in,
  // Writer side, write_tick_in marks a write clock edge
  input  wire logic                              write_tick_in,
  input  wire logic                              write_enable_n_in,
  input  wire logic [fifo_flag_pkg::DATA_W-1:0]  data_in,
  // Reader side, read_tick_in marks a read clock edge
  input  wire logic                              read_tick_in,
  input  wire logic                              read_enable_n_in,
  input  wire logic [fifo_flag_pkg::DATA_W-1:0]  mem_data_in,
  // Offset register access
  input  wire logic                              offset_load_in,
  input  wire logic                              offset_read_in,
  input  wire logic                              offset_sel_in,
  // Flags and data
  output logic                                   full_input_ready_out,
  output logic                                   empty_output_ready_out,
  output logic                                   almost_full_flag_out,
  output logic                                   almost_empty_flag_out,
  output logic                                   half_full_flag_out,
  output logic                                   write_accept_out,
  output logic                                   read_accept_out,
  output logic [fifo_flag_pkg::DATA_W-1:0]       data_out
);
  import fifo_flag_pkg::*;

  typedef logic [LEVEL_W-1:0] level_t;

  // Mode bits caught at master reset
  logic fall_through_mode_mode;
  logic sync_flags;
  logic interspersed;
  logic in_wide;
  logic out_wide;

  logic [OFS_W-1:0] empty_ofs;
  logic [OFS_W-1:0] full_ofs;

  level_t level;
  level_t next_level;
  level_t cap;
  level_t cap_eff;
  level_t half_thr;
  level_t ae_thr;
  level_t af_thr;

  logic running;
  logic full_raw;
  logic wr_ok;
  logic rd_ok;
  logic [FULL_STAGES-2:0] full_pipe;
  logic [OR_STAGES-1:0]   valid_pipe;

  // Strip parity bits from a parallel offset word
  function automatic logic [OFS_W-1:0] offset_from_bus(input logic ip,
                                                        input logic [DATA_W-1:0] d);
    if (ip) begin
      offset_from_bus = {d[PARITY_HI_BIT-1:PARITY_LO_BIT+1], d[PARITY_LO_BIT-1:0]};
    end else begin
      offset_from_bus = d[OFS_W-1:0];
    end
  endfunction : offset_from_bus

  // Place an offset back on the output bus, parity slots zero
  function automatic logic [DATA_W-1:0] offset_to_bus(input logic ip,
                                                       input logic [OFS_W-1:0] o);
    if (ip) begin
      offset_to_bus = {1'b0, o[OFS_W-1:PARITY_LO_BIT], 1'b0, o[PARITY_LO_BIT-1:0]};
    end else begin
      offset_to_bus = {2'b00, o};
    end
  endfunction : offset_to_bus

  assign running = master_reset_n_in && partial_reset_n_in;

  // Units follow the wider port, so two narrow ports double the depth
  assign cap      = (in_wide || out_wide) ? level_t'(DEPTH) : level_t'(2 * DEPTH);
  assign cap_eff  = fall_through_mode_mode ? cap + level_t'(1) : cap;
  assign half_thr = (cap >> 1) + (fall_through_mode_mode ? level_t'(1) : level_t'(0));
  assign ae_thr   = level_t'(empty_ofs) + (fall_through_mode_mode ? level_t'(1) : level_t'(0));
  assign af_thr   = cap_eff - level_t'(full_ofs);

  assign full_raw = (level >= cap_eff);
  assign wr_ok    = running && write_tick_in && !write_enable_n_in && !full_raw;

  // Reads are gated by the flag the reader sees, and in standard mode also by a nonzero raw count
  always_comb begin
    if (fall_through_mode_mode) begin
      rd_ok = running && read_tick_in && !read_enable_n_in && valid_pipe[OR_STAGES-1];
    end else begin
      rd_ok = running && read_tick_in && !read_enable_n_in && valid_pipe[EF_STAGES-1]
              && (level != level_t'(0));
    end
  end

  assign next_level = level + level_t'(wr_ok) - level_t'(rd_ok);

  // Straps
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fall_through_mode_mode    <= 1'b0;
      sync_flags   <= 1'b0;
      interspersed <= 1'b0;
      in_wide      <= 1'b1;
      out_wide     <= 1'b1;
    end else if (!master_reset_n_in) begin
      fall_through_mode_mode    <= fall_through_mode_in;
      sync_flags   <= prog_flag_timing_select_in;
      interspersed <= parity_placement_select_in;
      in_wide      <= in_wide_in;
      out_wide     <= out_wide_in;
    end
  end

  // Offsets survive a partial reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !master_reset_n_in) begin
      empty_ofs <= EMPTY_OFS_0;
      full_ofs  <= FULL_OFS_0;
    end else if (offset_load_in) begin
      if (offset_sel_in == SEL_FULL_OFS) begin
        full_ofs <= offset_from_bus(interspersed, data_in);
      end else begin
        empty_ofs <= offset_from_bus(interspersed, data_in);
      end
    end
  end

  // Word count, output register included in fall-through mode
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  // Full / input ready, two stages on write ticks
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      full_pipe <= '0;
    end else if (write_tick_in) begin
      // First stage only; the output register below is the second
      full_pipe[0] <= (next_level >= cap_eff);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      full_input_ready_out <= !fall_through_mode_mode;
    end else if (write_tick_in) begin
      // Active-high not-full in standard, active-low ready in fall-through
      full_input_ready_out <= fall_through_mode_mode ? full_pipe[0] : !full_pipe[0];
    end
  end

  // Valid chain on read ticks; an emptying read clears it at once
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      valid_pipe <= '0;
    end else if (read_tick_in) begin
      if (next_level == level_t'(0)) begin
        valid_pipe <= '0;
      end else if (fall_through_mode_mode && rd_ok) begin
        valid_pipe <= {valid_pipe[OR_STAGES-2:0], 1'b1} | {OR_STAGES{valid_pipe[0]}};
      end else begin
        valid_pipe <= {valid_pipe[OR_STAGES-2:0], 1'b1};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      empty_output_ready_out <= fall_through_mode_mode;
    end else if (read_tick_in) begin
      if (fall_through_mode_mode) begin
        empty_output_ready_out <= (next_level == level_t'(0)) ? 1'b1
                                  : !valid_pipe[OR_STAGES-2];
      end else begin
        empty_output_ready_out <= (next_level == level_t'(0)) ? 1'b0
                                  : valid_pipe[EF_STAGES-2];
      end
    end
  end

  // Almost full
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      almost_full_flag_out <= 1'b1;
    end else if (sync_flags) begin
      if (write_tick_in) begin
        almost_full_flag_out <= !(next_level >= af_thr);
      end
    end else if (write_tick_in && next_level >= af_thr) begin
      almost_full_flag_out <= 1'b0;
    end else if (read_tick_in && next_level < af_thr) begin
      almost_full_flag_out <= 1'b1;
    end
  end

  // Almost empty
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      almost_empty_flag_out <= 1'b0;
    end else if (sync_flags) begin
      if (read_tick_in) begin
        almost_empty_flag_out <= !(next_level <= ae_thr);
      end
    end else if (read_tick_in && next_level <= ae_thr) begin
      almost_empty_flag_out <= 1'b0;
    end else if (write_tick_in && next_level > ae_thr) begin
      almost_empty_flag_out <= 1'b1;
    end
  end

  // Half full: writes can only set it, reads can only clear it
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !running) begin
      half_full_flag_out <= 1'b1;
    end else if (write_tick_in && next_level > half_thr) begin
      half_full_flag_out <= 1'b0;
    end else if (read_tick_in && next_level <= half_thr) begin
      half_full_flag_out <= 1'b1;
    end
  end

  // Strobes to the storage array
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      write_accept_out <= 1'b0;
      read_accept_out  <= 1'b0;
    end else begin
      write_accept_out <= wr_ok;
      read_accept_out  <= rd_ok;
    end
  end

  // Output word; a narrow output port leaves the top bits of read data at zero
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      data_out <= '0;
    end else if (offset_read_in) begin
      data_out <= offset_to_bus(interspersed, (offset_sel_in == SEL_FULL_OFS)
                                ? full_ofs : empty_ofs);
    end else if (rd_ok) begin
      data_out <= out_wide ? mem_data_in
                  : {{(DATA_W-NARROW_W){1'b0}}, mem_data_in[NARROW_W-1:0]};
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ae_sync_hold: assert property (
    running && sync_flags && !read_tick_in |=> $stable(almost_empty_flag_out))
    else $error("almost-empty moved without a read tick");

  a_af_sync_hold: assert property (
    running && sync_flags && !write_tick_in |=> $stable(almost_full_flag_out))
    else $error("almost-full moved without a write tick");

  a_mode_strap: assert property (
    !master_reset_n_in |=> fall_through_mode_mode == $past(fall_through_mode_in))
    else $error("fall-through strap not captured");

  a_timing_strap: assert property (
    !master_reset_n_in |=> sync_flags == $past(prog_flag_timing_select_in))
    else $error("flag timing strap not captured");

  a_parity_strap: assert property (
    !master_reset_n_in |=> interspersed == $past(parity_placement_select_in))
    else $error("parity strap not captured");

  a_q8_parity: assert property (
    offset_read_in && interspersed |=> data_out[PARITY_LO_BIT] == 1'b0)
    else $error("parity slot not cleared on readback");

  a_no_overfill: assert property (
    level >= cap_eff |=> level <= $past(level))
    else $error("write accepted while full");

  a_reset_empty: assert property (
    !partial_reset_n_in |=> level == '0 && !almost_empty_flag_out && half_full_flag_out)
    else $error("reset did not leave flags empty");

  a_half_set: assert property (
    running && write_tick_in && next_level > half_thr |=> !half_full_flag_out)
    else $error("half-full not set on write tick");

  a_narrow_data: assert property (
    !out_wide && !offset_read_in ##1 $changed(data_out) |-> data_out[DATA_W-1:NARROW_W] == '0)
    else $error("narrow port drove upper data bits");

  a_ready_on_read: assert property (
    fall_through_mode_mode && running && $rose(empty_output_ready_out)
      |-> $past(read_tick_in && !read_enable_n_in))
    else $error("output ready rose without a true read");

  a_full_two_stage: assert property (
    running && !fall_through_mode_mode && write_tick_in && !read_tick_in && next_level >= cap_eff
      ##1 running && !write_tick_in && !read_tick_in
      ##1 running && write_tick_in && !read_tick_in |=> !full_input_ready_out)
    else $error("full flag missed its two-stage update");

  a_full_tick_only: assert property (
    running && !write_tick_in |=> $stable(full_input_ready_out))
    else $error("full flag moved without a write tick");

  a_empty_tick_only: assert property (
    running && !read_tick_in |=> $stable(empty_output_ready_out))
    else $error("empty flag moved without a read tick");

  a_ae_async_set: assert property (
    running && !sync_flags && read_tick_in && next_level <= ae_thr |=> !almost_empty_flag_out)
    else $error("almost-empty not set on read tick");

  a_af_async_set: assert property (
    running && !sync_flags && write_tick_in && next_level >= af_thr |=> !almost_full_flag_out)
    else $error("almost-full not set on write tick");

  a_empty_blocks_read: assert property (
    running && !fall_through_mode_mode && level == '0 |=> !read_accept_out)
    else $error("read accepted while empty");

  a_ready_blocks_read: assert property (
    running && fall_through_mode_mode && empty_output_ready_out |=> !read_accept_out)
    else $error("read accepted while output not ready");

  a_full_blocks_write: assert property (
    running && level >= cap_eff |=> !write_accept_out)
    else $error("write accepted while no space left");

  a_half_clear: assert property (
    running && read_tick_in && !write_tick_in && next_level <= half_thr |=> half_full_flag_out)
    else $error("half-full not cleared on read tick");

endmodule : fifo_flag_core

// >>> core/fifo_flag_pkg.sv
// Constants for the dual-clock FIFO status-flag block
package fifo_flag_pkg;
  localparam int          DEPTH_WORDS     = 8192;
  localparam int          LEVEL_W         = 15;
  localparam int          OFS_W           = 16;
  localparam int          DATA_W          = 18;
  localparam int          NARROW_W        = 9;
  localparam int          PARITY_LO_BIT   = 8;
  localparam int          PARITY_HI_BIT   = 17;
  localparam logic [15:0] EMPTY_OFS_RESET = 16'h007f;
  localparam logic [15:0] FULL_OFS_RESET  = 16'h007f;
  localparam logic        SEL_EMPTY_OFS   = 1'h0;
  localparam logic        SEL_FULL_OFS    = 1'h1;
  localparam int          FULL_STAGES     = 2;
  localparam int          EF_STAGES       = 2;
  localparam int          OR_STAGES       = 3;
endpackage : fifo_flag_pkg

// >>> sim/fifo_far_side.sv
// Writer and reader logic that face the flag block, one edge per task call
`timescale 1ns/1ps
module fifo_far_side (
  // Clock
  input  wire logic                         core_clk_in,
  // Writer and reader strobes, storage word
  output logic                              write_tick_out,
  output logic                              write_enable_n_out,
  output logic                              read_tick_out,
  output logic                              read_enable_n_out,
  output logic [fifo_flag_pkg::DATA_W-1:0]  mem_data_out
);
  import fifo_flag_pkg::*;
  int unsigned       gap   = 0;
  logic [DATA_W-1:0] word  = 18'h15a00;
  logic              phase = 1'b0;

  initial begin
    write_tick_out     = 1'b0;
    write_enable_n_out = 1'b1;
    read_tick_out      = 1'b0;
    read_enable_n_out  = 1'b1;
  end

  // Outside a read edge the storage word churns, so a late capture cannot pass
  always @(posedge core_clk_in) phase <= ~phase;
  assign mem_data_out = read_tick_out ? word : ~word ^ {{(DATA_W-1){1'b0}}, phase};

  // Write and read clocks are independent: each edge is issued on its own
  task automatic write_edge(input logic enable_n);
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    write_tick_out     <= 1'b1;
    write_enable_n_out <= enable_n;
    @(posedge core_clk_in);
    write_tick_out     <= 1'b0;
    write_enable_n_out <= 1'b1;
  endtask : write_edge

  task automatic read_edge(input logic enable_n);
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    read_tick_out     <= 1'b1;
    read_enable_n_out <= enable_n;
    @(posedge core_clk_in);
    read_tick_out     <= 1'b0;
    read_enable_n_out <= 1'b1;
    word              <= word + 18'h00013;
  endtask : read_edge
endmodule : fifo_far_side

// >>> sim/test_dual_clock_fifo_status_flags.sv
// Self-checking bench for the FIFO status-flag block
`timescale 1ns/1ps
module test_dual_clock_fifo_status_flags;
  import fifo_flag_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n, mrst_n, prst_n, fall_through_mode, prog_flag_timing_select, ipar, iwide, owide;
  logic              ofs_load, ofs_read, ofs_sel, wtick, wen_n, rtick, ren_n;
  logic              fir, eor, af, ae, hf, wacc, racc, fmode, smode;
  logic [DATA_W-1:0] din, mem_word, dout;
  wire  [4:0]        flags = {fir, eor, af, ae, hf};
  int                fails = 0;
  int                total_checks = 0;
  int                cycles = 0;
  int                lvl, cap, n, m;

  fifo_flag_core #(.DEPTH(8), .EMPTY_OFS_0(16'h0002), .FULL_OFS_0(16'h0002)) dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .master_reset_n_in(mrst_n),
    .partial_reset_n_in(prst_n), .fall_through_mode_in(fall_through_mode),
    .prog_flag_timing_select_in(prog_flag_timing_select), .parity_placement_select_in(ipar),
    .in_wide_in(iwide), .out_wide_in(owide), .write_tick_in(wtick),
    .write_enable_n_in(wen_n), .data_in(din), .read_tick_in(rtick),
    .read_enable_n_in(ren_n), .mem_data_in(mem_word), .offset_load_in(ofs_load),
    .offset_read_in(ofs_read), .offset_sel_in(ofs_sel), .full_input_ready_out(fir),
    .empty_output_ready_out(eor), .almost_full_flag_out(af), .almost_empty_flag_out(ae),
    .half_full_flag_out(hf), .write_accept_out(wacc), .read_accept_out(racc),
    .data_out(dout));

  fifo_far_side far (
    .core_clk_in(clk), .write_tick_out(wtick), .write_enable_n_out(wen_n),
    .read_tick_out(rtick), .read_enable_n_out(ren_n), .mem_data_out(mem_word));

  initial forever #25 clk = ~clk;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Run is about 2300 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic chk1(input string what, input logic seen, exp);
    check(what, DATA_W'(seen), DATA_W'(exp));
  endtask : chk1

  // Bits: full/ready-in, empty/ready-out, almost full, almost empty, half full
  function automatic logic [4:0] flags_for(input int lv);
    int c = cap + int'(fmode);
    return {fmode ? lv == c : lv != c, fmode ? lv == 0 : lv != 0, !(lv >= c - m),
            !(lv <= n + int'(fmode)), !(lv > cap / 2 + int'(fmode))};
  endfunction : flags_for

  task automatic dev_reset(input logic master);
    @(posedge clk);
    if (master) mrst_n <= 1'b0;
    else prst_n <= 1'b0;
    repeat (3) @(posedge clk);
    mrst_n <= 1'b1;
    prst_n <= 1'b1;
    @(negedge clk);
    lvl = 0;
    check("reset flags", DATA_W'(flags), DATA_W'(flags_for(0)));
  endtask : dev_reset

  task automatic ofs_set(input logic sel, input logic [15:0] v, input logic load);
    @(posedge clk);
    ofs_sel  <= sel;
    din      <= ipar ? {1'b1, v[15:8], 1'b1, v[7:0]} : {2'b11, v};
    ofs_load <= load;
    @(posedge clk);
    ofs_load <= 1'b0;
    ofs_read <= 1'b1;
    @(posedge clk);
    ofs_read <= 1'b0;
    @(negedge clk);
    if (owide) check("offset", dout, ipar ? {1'b0, v[15:8], 1'b0, v[7:0]} : {2'b00, v});
  endtask : ofs_set

  // One write or read, then idle edges on both sides so every stage settles
  task automatic step(input logic wr);
    logic [4:0]        was, now;
    logic [DATA_W-1:0] w;
    logic              ok;
    int                k;
    was = flags_for(lvl);
    w   = far.word;
    ok  = wr ? (lvl < cap + int'(fmode)) : (lvl > 0);
    if (wr) far.write_edge(1'b0);
    else far.read_edge(1'b0);
    @(negedge clk);
    lvl = ok ? (wr ? lvl + 1 : lvl - 1) : lvl;
    now = flags_for(lvl);
    chk1("accept", wr ? wacc : racc, ok);
    chk1("half full", hf, now[0]);
    if (wr) chk1("full stage", fir, was[4]);
    if (wr) chk1("almost empty", ae, smode ? was[1] : now[1]);
    else chk1("almost full", af, smode ? was[2] : now[2]);
    if (!wr && ok) check("read data", dout, owide ? w : {9'h0, w[NARROW_W-1:0]});
    if (!wr && fmode) chk1("ready out", eor, now[3]);
    for (k = 1; k <= 3; k++) begin
      far.write_edge(1'b1);
      @(negedge clk);
      if (wr && k < 3) chk1("full stage", fir, now[4]);
    end
    for (k = 1; k <= 3; k++) begin
      far.read_edge(1'b1);
      @(negedge clk);
      if (wr) chk1("empty stage", eor, k >= 2 + int'(fmode) ? now[3] : was[3]);
    end
    check("flags", DATA_W'(flags), DATA_W'(now));
  endtask : step

  task automatic run_config(input logic f, s, p, wi, wo, input int g);
    int i;
    @(posedge clk);
    fall_through_mode  <= f;
    prog_flag_timing_select   <= s;
    ipar  <= p;
    iwide <= wi;
    owide <= wo;
    fmode = f;
    smode = s;
    far.gap = g;
    cap = (wi || wo) ? 8 : 16;
    n = 2;
    m = 2;
    dev_reset(1'b1);
    ofs_set(1'b0, 16'h0002, 1'b0);
    ofs_set(1'b1, 16'h8105, 1'b1);
    ofs_set(1'b1, 16'h0003, 1'b1);
    ofs_set(1'b0, 16'h0001, 1'b1);
    n = 1;
    m = 3;
    for (i = 0; i <= cap + int'(fmode); i++) step(1'b1);
    for (i = 0; i <= cap + int'(fmode); i++) step(1'b0);
    repeat (3) step(1'b1);
    dev_reset(1'b0);
    ofs_set(1'b1, 16'h0003, 1'b0);
    step(1'b1);
    $display("Test fall_through_mode=%0d sync=%0d done, mismatches %0d", f, s, fails);
  endtask : run_config

  initial begin
    rst_n    = 1'b0;
    mrst_n   = 1'b0;
    prst_n   = 1'b1;
    fall_through_mode     = 1'b0;
    prog_flag_timing_select      = 1'b0;
    ipar     = 1'b0;
    iwide    = 1'b1;
    owide    = 1'b1;
    ofs_load = 1'b0;
    ofs_read = 1'b0;
    ofs_sel  = 1'b0;
    din      = 18'h00000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    run_config(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 0);
    run_config(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1);
    // Core reset in mid-run drops the straps back to their defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("core reset flags", DATA_W'(flags), 18'h00015);
    check("core reset data", dout, 18'h00000);
    run_config(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 0);
    run_config(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1);
    run_config(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 0);
    finish_test();
  end
endmodule : test_dual_clock_fifo_status_flags
